// ---- hw/clock_status_consts.vh ----
// constants for the clock selection and status block
`ifndef CLOCK_STATUS_CONSTS_VH
`define CLOCK_STATUS_CONSTS_VH
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_AES_SYNC    8'h08
`define OFF_AES_FLASH   8'h0C
`define OFF_AES_DS      8'h10
`define OFF_AES_QS      8'h14
`define OFF_AES_AUDIO   8'h18
`define OFF_AES_ERR     8'h1C
`define OFF_SAVED       8'h20
`define CTRL_RESET      32'h0000_0000
`define CTRL_WMASK      32'h0000_03FF
`define F_CLK_LO        0
`define F_CLK_HI        2
`define F_SPD_LO        3
`define F_SPD_HI        4
`define F_FMT64         5
`define F_FRAME96       6
`define F_REMOTE_MADI   7
`define F_KEY_LOCK      8
`define F_COAX          9
`define CLK_AES         3'd0
`define CLK_MADI        3'd1
`define CLK_WORD        3'd2
`define CLK_INT441      3'd3
`define CLK_INT48       3'd4
`define CLK_LAST        3'd4
`define SPD_SINGLE      2'd0
`define SPD_DOUBLE      2'd1
`define SPD_QUAD        2'd2
`define WINDOW_US       1000
`define CLK_MHZ         100
`define WINDOW_CYC      (`WINDOW_US * `CLK_MHZ)
`define DS_LO_KHZ       60
`define DS_HI_KHZ       100
`define QS_LO_KHZ       162
`define QS_HI_KHZ       200
`define F96_LO_KHZ      64
`define F96_HI_KHZ      96
`define FLASH_MS        250
`define FLASH_CYC       (`FLASH_MS * 1000 * `CLK_MHZ)
`endif

// ---- hw/clock_status.v ----
// clock reference selection, rate classification and status indication
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "clock_status_consts.vh"
module clock_status #(
    parameter N_AES      = 32,
    parameter WINDOW_CYC = `WINDOW_CYC,
    parameter FLASH_CYC  = `FLASH_CYC
) (
    // clock and reset
    input  wire              aclk,
    input  wire              aresetn,
    // axi4-lite slave
    input  wire [7:0]        s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [7:0]        s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // front panel buttons, one-cycle pulses from debounced logic
    input  wire              btn_clock,
    input  wire              btn_speed,
    input  wire              btn_format,
    input  wire              btn_frame,
    input  wire              btn_remote,
    input  wire              btn_input,
    input  wire              btn_lock,
    // retained settings
    input  wire [9:0]        saved_settings,
    input  wire              saved_valid,
    output reg  [9:0]        store_settings,
    // link side inputs, asynchronous
    input  wire [N_AES-1:0]  aes_frame,
    input  wire [N_AES-1:0]  aes_lock,
    input  wire [N_AES-1:0]  aes_sync,
    input  wire [N_AES-1:0]  aes_nonzero,
    input  wire              word_clk,
    input  wire              word_lock,
    input  wire              madi_opt_lock,
    input  wire              madi_coax_lock,
    input  wire              madi_opt_sync,
    input  wire              madi_coax_sync,
    input  wire              madi_in_64ch,
    input  wire              madi_in_96k,
    // indicators and datapath controls
    output reg  [N_AES-1:0]  aes_sync_led,
    output reg  [N_AES-1:0]  aes_audio_led,
    output reg               aes_error_led,
    output reg               double_speed_indicator,
    output reg               quad_speed_indicator,
    output reg               word_error_led,
    output reg               word_double_speed_indicator,
    output reg               word_quad_speed_indicator,
    output reg               madi_sync_led,
    output reg               madi_error_led,
    output reg               madi_64ch_led,
    output reg               madi_96k_led,
    output reg               madi_in_coax,
    output reg               madi_out_64ch,
    output reg               madi_out_96k,
    output reg               remote_from_madi,
    output reg  [2:0]        clock_ref,
    output reg  [1:0]        speed_range,
    output reg  [2:0]        base_rate_sel
);
    localparam NS = 4 * N_AES + 5;
    reg [NS-1:0]  s1_reg;
    reg [NS-1:0]  s2_reg;
    reg [N_AES:0] prev_reg;
    reg [31:0]    ctrl_reg;
    reg [31:0]    win_reg;
    reg [31:0]    flash_reg;
    reg           blink_reg;
    reg [15:0]    cnt_reg   [0:N_AES];
    reg [15:0]    rate_reg  [0:N_AES];
    reg           aw_seen_reg;
    reg           w_seen_reg;
    reg [7:0]     awaddr_reg;
    reg [31:0]    wdata_reg;
    reg [3:0]     wstrb_reg;
    reg           restored_reg;
    reg [N_AES-1:0] ds_vec;
    reg [N_AES-1:0] qs_vec;
    integer       i;
    integer       j;
    wire [N_AES-1:0] fr_s  = s2_reg[N_AES-1:0];
    wire [N_AES-1:0] lk_s  = s2_reg[2*N_AES-1:N_AES];
    wire [N_AES-1:0] sy_s  = s2_reg[3*N_AES-1:2*N_AES];
    wire [N_AES-1:0] nz_s  = s2_reg[4*N_AES-1:3*N_AES];
    wire [4:0]       misc  = s2_reg[NS-1:4*N_AES];
    wire             wc_s  = misc[0];
    wire             mcoax = ctrl_reg[`F_COAX];
    wire             m_lock = mcoax ? misc[2] : misc[1];
    wire             m_sync = mcoax ? misc[4] : misc[3];
    wire [2:0]       cref  = ctrl_reg[`F_CLK_HI:`F_CLK_LO];
    wire [1:0]       spd   = ctrl_reg[`F_SPD_HI:`F_SPD_LO];
    wire [N_AES:0]   edges = {wc_s, fr_s} & ~prev_reg;
    wire [15:0]      wrate = rate_reg[N_AES];
    // frames per window of 1 ms read as kHz directly
    function in_band;
        input [15:0] r;
        input [31:0] lo;
        input [31:0] hi;
        in_band = ({16'h0000, r} >= lo) && ({16'h0000, r} <= hi);
    endfunction
    // rate of the current reference: aes input 0 stands for the aes group
    wire [15:0] ref_rate = (cref == `CLK_AES)  ? rate_reg[0] :
                           (cref == `CLK_WORD) ? rate_reg[N_AES] :
                           (cref == `CLK_INT441) ? 16'd44 << spd : 16'd48 << spd;
    wire allow96 = in_band(ref_rate, `F96_LO_KHZ, `F96_HI_KHZ) && (cref != `CLK_MADI ||
                   madi_96k_led);
    // front panel settings; lockout blocks every press but unlock
    reg [31:0] pan;
    always @*
    begin
        pan = ctrl_reg;
        if (!ctrl_reg[`F_KEY_LOCK])
        begin
            if (btn_clock)
                pan[`F_CLK_HI:`F_CLK_LO] = (cref >= `CLK_LAST) ? `CLK_AES : cref + 3'd1;
            if (btn_speed)
                pan[`F_SPD_HI:`F_SPD_LO] = (spd >= `SPD_QUAD) ? `SPD_SINGLE : spd + 2'd1;
            pan[`F_FMT64] = ctrl_reg[`F_FMT64] ^ btn_format;
            pan[`F_FRAME96] = ctrl_reg[`F_FRAME96] ^ btn_frame;
            pan[`F_REMOTE_MADI] = ctrl_reg[`F_REMOTE_MADI] ^ btn_remote;
            pan[`F_COAX] = ctrl_reg[`F_COAX] ^ btn_input;
        end
        pan[`F_KEY_LOCK] = ctrl_reg[`F_KEY_LOCK] ^ btn_lock;
    end
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {s1_reg, s2_reg} <= {(2*NS){1'b0}};
            prev_reg <= {(N_AES+1){1'b0}};
            {win_reg, flash_reg} <= 64'h0000_0000_0000_0000;
            blink_reg <= 1'b0;
            for (i = 0; i <= N_AES; i = i + 1)
            begin
                cnt_reg[i] <= 16'h0000;
                rate_reg[i] <= 16'h0000;
            end
        end
        else
        begin
            s1_reg <= {madi_coax_sync, madi_opt_sync, madi_coax_lock, madi_opt_lock,
                       word_clk, aes_nonzero, aes_sync, aes_lock, aes_frame};
            s2_reg <= s1_reg;
            prev_reg <= {wc_s, fr_s};
            // frame counting against a fixed internal window
            if (win_reg == WINDOW_CYC - 1)
            begin
                win_reg <= 32'h0000_0000;
                for (i = 0; i <= N_AES; i = i + 1)
                begin
                    rate_reg[i] <= cnt_reg[i] + {15'h0000, edges[i]};
                    cnt_reg[i] <= 16'h0000;
                end
            end
            else
            begin
                win_reg <= win_reg + 32'h0000_0001;
                for (i = 0; i <= N_AES; i = i + 1)
                    cnt_reg[i] <= cnt_reg[i] + {15'h0000, edges[i]};
            end
            if (flash_reg == FLASH_CYC - 1)
            begin
                flash_reg <= 32'h0000_0000;
                blink_reg <= ~blink_reg;
            end
            else
                flash_reg <= flash_reg + 32'h0000_0001;
        end
    end
    // settings and axi4-lite slave; bus writes win over panel presses
    wire do_write = aw_seen_reg && w_seen_reg && !s_axi_bvalid;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg <= `CTRL_RESET;
            restored_reg <= 1'b0;
            {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid} <= 5'h00;
            {s_axi_bresp, s_axi_rresp} <= 4'h0;
            s_axi_rdata <= 32'h0000_0000;
            {aw_seen_reg, w_seen_reg} <= 2'h0;
            // held address and data need no reset: read only once both halves landed
        end
        else
        begin
            if (!restored_reg && saved_valid)
            begin
                ctrl_reg <= {22'h00_0000, saved_settings};
                restored_reg <= 1'b1;
            end
            else if (do_write && awaddr_reg == `OFF_CTRL)
            begin
                if (wstrb_reg[0])
                    ctrl_reg[7:0] <= wdata_reg[7:0];
                if (wstrb_reg[1])
                    ctrl_reg[9:8] <= wdata_reg[9:8];
            end
            else
                ctrl_reg <= pan & `CTRL_WMASK;
            s_axi_awready <= !aw_seen_reg && s_axi_awvalid && !s_axi_awready;
            s_axi_wready <= !w_seen_reg && s_axi_wvalid && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_seen_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_seen_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_reg == `OFF_CTRL) ? 2'b00 : 2'b10;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_seen_reg <= 1'b0;
                w_seen_reg <= 1'b0;
            end
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    `OFF_CTRL:      s_axi_rdata <= ctrl_reg;
                    `OFF_STATUS:    s_axi_rdata <= {16'h0000, ref_rate};
                    `OFF_AES_SYNC:  s_axi_rdata <= aes_sync_led;
                    `OFF_AES_FLASH: s_axi_rdata <= lk_s & ~sy_s;
                    `OFF_AES_DS:    s_axi_rdata <= {N_AES{1'b0}} | ds_vec;
                    `OFF_AES_QS:    s_axi_rdata <= {N_AES{1'b0}} | qs_vec;
                    `OFF_AES_AUDIO: s_axi_rdata <= aes_audio_led;
                    `OFF_AES_ERR:   s_axi_rdata <= ~lk_s;
                    `OFF_SAVED:     s_axi_rdata <= {22'h00_0000, store_settings};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
    always @*
    begin
        for (j = 0; j < N_AES; j = j + 1)
        begin
            ds_vec[j] = lk_s[j] && in_band(rate_reg[j], `DS_LO_KHZ, `DS_HI_KHZ);
            qs_vec[j] = lk_s[j] && in_band(rate_reg[j], `QS_LO_KHZ, `QS_HI_KHZ);
        end
    end
    // indicators; flashing uses a slow enable rather than a second clock
    wire wsel = (cref == `CLK_WORD);
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {aes_sync_led, aes_audio_led} <= {(2*N_AES){1'b0}};
            {aes_error_led, double_speed_indicator, quad_speed_indicator} <= 3'h0;
            {word_error_led, word_double_speed_indicator, word_quad_speed_indicator} <= 3'h0;
            {madi_sync_led, madi_error_led, madi_64ch_led, madi_96k_led} <= 4'h0;
            {madi_in_coax, madi_out_64ch, madi_out_96k, remote_from_madi} <= 4'h0;
            clock_ref <= `CLK_AES;
            speed_range <= `SPD_SINGLE;
            base_rate_sel <= `CLK_AES;
            store_settings <= 10'h000;
        end
        else
        begin
            aes_sync_led <= lk_s & (sy_s | {N_AES{blink_reg}});
            aes_audio_led <= lk_s & nz_s;
            aes_error_led <= ~lk_s[0];
            double_speed_indicator <= ds_vec[0];
            quad_speed_indicator <= qs_vec[0];
            word_error_led <= wsel && !word_lock;
            word_double_speed_indicator <= wsel && in_band(wrate, `DS_LO_KHZ, `DS_HI_KHZ);
            word_quad_speed_indicator <= wsel && in_band(wrate, `QS_LO_KHZ, `QS_HI_KHZ);
            madi_sync_led <= m_lock && (m_sync || blink_reg);
            madi_error_led <= !m_lock;
            madi_64ch_led <= m_lock && madi_in_64ch;
            madi_96k_led <= m_lock && madi_in_96k;
            madi_in_coax <= mcoax;
            madi_out_64ch <= ctrl_reg[`F_FMT64];
            madi_out_96k <= ctrl_reg[`F_FRAME96] && allow96;
            remote_from_madi <= ctrl_reg[`F_REMOTE_MADI];
            clock_ref <= cref;
            speed_range <= spd;
            base_rate_sel <= cref;
            store_settings <= ctrl_reg[9:0];
        end
    end
endmodule // clock_status

// ---- testbench/clock_status_asserts.sv ----
// concurrent checks on the clock selection and status block ports
`timescale 1ns/1ps
`include "clock_status_consts.vh"
module clock_status_asserts #(
    parameter N_AES = 32
) (
    // clock and reset
    input wire logic             aclk,
    input wire logic             aresetn,
    // register bus read address handshake and read data valid
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic             s_axi_rvalid,
    // panel and settings
    input wire logic             btn_clock,
    input wire logic [9:0]       store_settings,
    // aes inputs and indicators
    input wire logic [N_AES-1:0] aes_lock,
    input wire logic [N_AES-1:0] aes_sync,
    input wire logic [N_AES-1:0] aes_nonzero,
    input wire logic [N_AES-1:0] aes_sync_led,
    input wire logic [N_AES-1:0] aes_audio_led,
    input wire logic             aes_error_led,
    input wire logic             double_speed_indicator,
    input wire logic             quad_speed_indicator,
    // word clock indicators
    input wire logic             word_error_led,
    input wire logic             word_double_speed_indicator,
    input wire logic             word_quad_speed_indicator,
    // clock and output controls
    input wire logic             madi_out_96k,
    input wire logic [2:0]       clock_ref,
    input wire logic [1:0]       speed_range
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // async levels pass two sync stages and a register, so four quiet cycles settle them
    sequence levels_settled;
        ($stable(aes_lock) && $stable(aes_sync) && $stable(aes_nonzero)) [*4];
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence press_free;
        btn_clock && !store_settings[`F_KEY_LOCK];
    endsequence

    chk_read_answer: assert property (
        ar_taken |=> s_axi_rvalid)
        else $error("read data late after address handshake");
    chk_clock_step: assert property (
        press_free |-> ##2 clock_ref ==
        (($past(clock_ref, 2) == `CLK_LAST) ? 3'd0 : $past(clock_ref, 2) + 3'd1))
        else $error("clock reference did not step");
    chk_key_lockout: assert property (
        btn_clock && store_settings[`F_KEY_LOCK] |-> ##2 clock_ref == $past(clock_ref, 2))
        else $error("press changed clock reference under lockout");
    chk_word_dark: assert property (
        (clock_ref != `CLK_WORD) [*4] |->
        !(word_error_led || word_double_speed_indicator || word_quad_speed_indicator))
        else $error("word indicator lit without word reference");
    chk_band_excl: assert property (
        !(double_speed_indicator && quad_speed_indicator))
        else $error("double and quad indicators lit together");
    chk_frame96_gate: assert property (
        (clock_ref >= `CLK_INT441 && speed_range != `SPD_DOUBLE) [*4] |-> !madi_out_96k)
        else $error("96k framing outside double speed");
    chk_sync_steady: assert property (
        levels_settled |-> (aes_sync_led & aes_lock & aes_sync) == (aes_lock & aes_sync))
        else $error("synchronous input sync indicator not steady");
    chk_audio_pair: assert property (
        levels_settled |-> aes_audio_led == (aes_lock & aes_nonzero))
        else $error("audio indicator mismatch");
    chk_error_led: assert property (
        levels_settled |-> aes_error_led == !aes_lock[0])
        else $error("input error indicator mismatch");
endmodule // clock_status_asserts

bind clock_status clock_status_asserts #(.N_AES(N_AES)) clock_status_asserts_i (.*);

// ---- testbench/link_source_model.sv ----
// far-side sources: aes frame edges and word clock
`timescale 1ns/1ps
module link_source_model #(
    parameter N_AES = 32
) (
    // control from the bench
    input  wire logic        run,
    input  wire logic [31:0] aes_half_ns,
    // link edges into the block
    output logic [N_AES-1:0] aes_frame,
    output logic             word_clk
);
    // lines rest low between bursts rather than holding a stale level
    initial
    begin
        aes_frame = '0;
        forever
        begin
            #(aes_half_ns);
            aes_frame = run ? ~aes_frame : '0;
        end
    end
    // word clock at 160 ns, so one window counts the double speed band
    initial
    begin
        word_clk = 1'b0;
        forever
        begin
            #80;
            word_clk = run ? ~word_clk : 1'b0;
        end
    end
endmodule // link_source_model

// ---- testbench/audio_interface_clock_status_tb_top.sv ----
// self-checking bench for the clock selection and status block
`timescale 1ns/1ps
`include "clock_status_consts.vh"
module audio_interface_clock_status_tb_top;
    localparam int WIN = 1280;
    logic        aclk, aresetn, run, saved_valid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, speed_range;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        btn_clock, btn_speed, btn_format, btn_frame, btn_remote, btn_input, btn_lock;
    logic [6:0]  btns;
    logic [9:0]  saved_settings, store_settings;
    logic [31:0] aes_frame, aes_lock, aes_sync, aes_nonzero, aes_sync_led, aes_audio_led;
    logic        word_clk, word_lock, madi_opt_lock, madi_coax_lock, madi_opt_sync;
    logic        madi_coax_sync, madi_in_64ch, madi_in_96k, aes_error_led, madi_sync_led;
    logic        double_speed_indicator, quad_speed_indicator, word_error_led;
    logic        word_double_speed_indicator, word_quad_speed_indicator, madi_error_led;
    logic        madi_64ch_led, madi_96k_led, madi_in_coax, madi_out_64ch, madi_out_96k;
    logic        remote_from_madi;
    logic [2:0]  clock_ref, base_rate_sel;
    int          half_ns = 80;
    int          n_fail = 0;
    int          samples_checked = 0;

    assign {btn_lock, btn_input, btn_remote, btn_frame, btn_format, btn_speed, btn_clock} = btns;
    clock_status #(.WINDOW_CYC(WIN), .FLASH_CYC(8)) clock_status_i (.*);
    link_source_model link_source_model_i (.run(run), .aes_half_ns(half_ns),
        .aes_frame(aes_frame), .word_clk(word_clk));
    always #5 aclk = ~aclk;

    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic late(input int n);
        if (n >= 50)
        begin
            n_fail++;
            conclude();
        end
    endtask
    // bready and rready stay high, so the answer is taken the edge it appears
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        r = s_axi_bresp;
        late(n);
    endtask
    task automatic rck(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        late(n);
        cmp(s_axi_rdata, e);
        cmp(32'(s_axi_rresp), 32'(er));
    endtask
    // settle time first so a preceding bus write has reached the outputs
    task automatic press(input int b);
        repeat (2) @(posedge aclk);
        btns <= 7'(1 << b);
        @(posedge aclk);
        btns <= 7'h00;
        repeat (4) @(posedge aclk);
    endtask

    task automatic t_restore;
        saved_settings <= 10'h2A1;
        saved_valid <= 1'b1;
        repeat (8) @(posedge aclk);
        rck(`OFF_CTRL, 32'h0000_02A1, 2'b00);
        cmp(32'(store_settings), 32'h0000_02A1);
        cmp(32'({madi_out_64ch, remote_from_madi, madi_in_coax}), 32'h0000_0007);
        cmp(32'({madi_64ch_led, madi_96k_led}), 32'h0000_0003);
        cmp(32'({madi_sync_led, madi_error_led}), 32'h0000_0002);
    endtask
    task automatic t_regs;
        logic [1:0] r;
        wr(`OFF_CTRL, 32'hFFFF_FC04, r);
        cmp(32'(r), 32'h0000_0000);
        rck(`OFF_CTRL, 32'h0000_0004, 2'b00);
        wr(`OFF_STATUS, 32'h0000_0001, r);
        cmp(32'(r), 32'h0000_0002);
        rck(8'h3C, 32'h0000_0000, 2'b10);
    endtask
    task automatic t_clock;
        logic [1:0] r;
        wr(`OFF_CTRL, 32'h0000_0000, r);
        for (int i = 1; i <= 5; i++)
        begin
            press(0);
            cmp(32'(clock_ref), 32'(i % 5));
            cmp(32'(base_rate_sel), 32'(i % 5));
        end
    endtask
    task automatic t_lock;
        logic [1:0] r;
        wr(`OFF_CTRL, 32'h0000_0102, r);
        for (int b = 0; b < 6; b++)
            press(b);
        rck(`OFF_CTRL, 32'h0000_0102, 2'b00);
        press(6);
        rck(`OFF_CTRL, 32'h0000_0002, 2'b00);
    endtask
    task automatic t_rates;
        logic [1:0] r;
        logic [9:0] c [6] = '{10'h044, 10'h04C, 10'h054, 10'h04B, 10'h053, 10'h00C};
        int         k [6] = '{48, 96, 192, 88, 176, 96};
        logic [5:0] f = 6'h0A;
        for (int i = 0; i < 6; i++)
        begin
            wr(`OFF_CTRL, 32'(c[i]), r);
            repeat (6) @(posedge aclk);
            rck(`OFF_STATUS, 32'(k[i]), 2'b00);
            cmp(32'(speed_range), 32'(c[i][4:3]));
            cmp(32'(madi_out_96k), 32'(f[i]));
        end
    endtask
    task automatic t_bands;
        logic [1:0] r;
        int h [3] = '{80, 36, 160};
        int e [3] = '{2, 1, 0};
        wr(`OFF_CTRL, 32'h0000_0000, r);
        run <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            half_ns = h[i];
            repeat (3 * WIN) @(posedge aclk);
            cmp(32'({double_speed_indicator, quad_speed_indicator}), 32'(e[i]));
            cmp(32'(word_double_speed_indicator), 32'h0000_0000);
        end
        wr(`OFF_CTRL, 32'(`CLK_WORD), r);
        repeat (3 * WIN) @(posedge aclk);
        cmp(32'({word_error_led, word_double_speed_indicator, word_quad_speed_indicator}),
            32'h0000_0002);
        run <= 1'b0;
    endtask
    task automatic t_leds;
        logic [31:0] lo;
        logic [31:0] hi;
        aes_lock <= 32'hF0F0_F0F1;
        aes_sync <= 32'h00FF_00FF;
        aes_nonzero <= 32'h0F0F_0F0F;
        repeat (8) @(posedge aclk);
        lo = '1;
        hi = '0;
        repeat (40)
        begin
            @(posedge aclk);
            lo &= aes_sync_led;
            hi |= aes_sync_led;
        end
        cmp(hi, 32'hF0F0_F0F1);
        cmp(lo, 32'h00F0_00F1);
        cmp(aes_audio_led, 32'h0000_0001);
        cmp(32'(aes_error_led), 32'h0000_0000);
        aes_lock <= 32'hF0F0_F0F0;
        repeat (8) @(posedge aclk);
        cmp(32'(aes_error_led), 32'h0000_0001);
    endtask

    initial
    begin
        aclk = 1'b0;
        aresetn = 1'b0;
        run = 1'b0;
        btns = 7'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        s_axi_wstrb = 4'hF;
        {s_axi_bready, s_axi_rready} = 2'b11;
        saved_settings = 10'h000;
        saved_valid = 1'b0;
        aes_lock = 32'hFFFF_FFFF;
        aes_sync = 32'hFFFF_FFFF;
        aes_nonzero = 32'h0000_0000;
        {word_lock, madi_opt_lock, madi_coax_lock, madi_opt_sync} = 4'hF;
        {madi_coax_sync, madi_in_64ch, madi_in_96k} = 3'h7;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_restore();
        t_regs();
        t_clock();
        t_lock();
        t_rates();
        t_bands();
        t_leds();
        conclude();
    end
endmodule // audio_interface_clock_status_tb_top
